//--- rtl/duty_if.sv
// Link between the sequencer and the supply duty guard.
`timescale 1ns/10ps
interface duty_if;
  logic vcc_on;
  logic rest_ok;
  modport ctrl  (output vcc_on, input rest_ok);
  modport guard (input vcc_on, output rest_ok);
endinterface : duty_if

//--- rtl/prom_host.sv
// Host controller that reads and programs a fuse memory of 8192 bytes.
//
// Overview of operation
// - One select decodes this device in wide space.
// - Apply word address and pull select low first.
// - Raise supply, check target bit still zero.
// - Drive select to programming voltage to enable.
// - Current into exactly one output, others open.
// - Ramp current, hold after drop, then off.
// - Lower select voltage, verify, then lower supply.
// - Elevated supply on at most half the period.
// - Retry unblown bit, sixteen attempts at most.
// - Bit blown at maximum current fails device.
// - Bit blown below maximum, continue with next.
`timescale 1ns/10ps
`include "prom_map.svh"
module prom_host
  import prom_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_rd_req,
  input  wire logic        i_pg_req,
  input  wire logic [12:0] i_addr,
  input  wire logic [2:0]  i_bit,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_sense_drop,
  input  wire logic        i_ramp_at_max,
  output logic      [12:0] o_addr,
  output logic             o_sel_n,
  output logic             o_sel_hv,
  output logic             o_vcc_hi,
  output logic             o_ramp_en,
  output logic             o_ramp_hold,
  output logic      [7:0]  o_ramp_oe,
  output logic      [7:0]  o_rdata,
  output logic             o_rd_valid,
  output logic             o_busy,
  output logic             o_pg_done,
  output logic             o_pg_ok,
  output logic             o_fail
);

  localparam logic [15:0] RD_CYC   = 16'(`PROM_RD_CYC);
  localparam logic [15:0] VCC_CYC  = 16'(`PROM_VCC_CYC);
  localparam logic [15:0] HV_CYC   = 16'(`PROM_HV_CYC);
  localparam logic [15:0] HOLD_CYC = 16'(`PROM_HOLD_CYC);
  localparam logic [15:0] OFF_CYC  = 16'(`PROM_OFF_CYC);

  host_regs_t r;
  host_regs_t next_r;
  logic       busy;
  logic       verify_bit;
  duty_if     du ();

  assign du.vcc_on  = r.vcc_hi;
  assign verify_bit = bit_of(i_data, r.bsel);

  supply_duty_guard u_guard (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .du     (du)
  );

  always_comb
  begin
    next_r          = r;
    next_r.rd_valid = 1'b0;
    next_r.pg_done  = 1'b0;
    if (r.tmr != 16'h0)
      next_r.tmr = r.tmr - 16'h1;
    unique case (r.st)
      ST_IDLE:
      begin
        if (i_rd_req)
        begin
          // Only this device's select is driven, so a wider space is decoded on select alone.
          next_r.addr  = i_addr;
          next_r.sel_n = 1'b0;
          next_r.tmr   = RD_CYC;
          next_r.st    = ST_RD_WAIT;
        end
        else if (i_pg_req && r.fail)
        begin
          next_r.pg_done = 1'b1;
          next_r.pg_ok   = 1'b0;
        end
        else if (i_pg_req)
        begin
          next_r.addr  = i_addr;
          next_r.bsel  = i_bit;
          next_r.sel_n = 1'b0;
          next_r.tries = 5'h0;
          next_r.pg_ok = 1'b0;
          next_r.st    = ST_REST;
        end
      end
      ST_RD_WAIT:
      begin
        if (r.tmr == 16'h0)
        begin
          next_r.rdata    = i_data;
          next_r.rd_valid = 1'b1;
          next_r.sel_n    = 1'b1;
          next_r.st       = ST_IDLE;
        end
      end
      ST_REST:
      begin
        if (du.rest_ok)
        begin
          next_r.vcc_hi = 1'b1;
          next_r.tmr    = VCC_CYC;
          next_r.st     = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (r.tmr == 16'h0)
        begin
          next_r.rdata = i_data;
          if (verify_bit)
          begin
            // A bit that already reads one needs no current; burning it again risks the cell.
            next_r.vcc_hi  = 1'b0;
            next_r.sel_n   = 1'b1;
            next_r.pg_done = 1'b1;
            next_r.pg_ok   = 1'b1;
            next_r.st      = ST_IDLE;
          end
          else
          begin
            next_r.sel_hv = 1'b1;
            next_r.tmr    = HV_CYC;
            next_r.st     = ST_HV;
          end
        end
      end
      ST_HV:
      begin
        if (r.tmr == 16'h0)
        begin
          next_r.ramp_en = 1'b1;
          next_r.ramp_oe = lane_of(r.bsel);
          next_r.at_max  = 1'b0;
          next_r.st      = ST_RAMP;
        end
      end
      ST_RAMP:
      begin
        if (i_sense_drop)
        begin
          next_r.ramp_hold = 1'b1;
          next_r.at_max    = i_ramp_at_max;
          next_r.tmr       = HOLD_CYC;
          next_r.st        = ST_HOLD;
        end
        else if (i_ramp_at_max)
        begin
          // No drop by full current: stop here and let the verify read decide.
          next_r.ramp_en = 1'b0;
          next_r.ramp_oe = 8'h00;
          next_r.at_max  = 1'b1;
          next_r.tmr     = OFF_CYC;
          next_r.st      = ST_CUR_OFF;
        end
      end
      ST_HOLD:
      begin
        if (r.tmr == 16'h0)
        begin
          next_r.ramp_en   = 1'b0;
          next_r.ramp_hold = 1'b0;
          next_r.ramp_oe   = 8'h00;
          next_r.tmr       = OFF_CYC;
          next_r.st        = ST_CUR_OFF;
        end
      end
      ST_CUR_OFF:
      begin
        if (r.tmr == 16'h0)
        begin
          next_r.sel_hv = 1'b0;
          next_r.tmr    = HV_CYC;
          next_r.st     = ST_VERIFY;
        end
      end
      ST_VERIFY:
      begin
        if (r.tmr == 16'h0)
        begin
          next_r.rdata  = i_data;
          next_r.vcc_hi = 1'b0;
          next_r.tries  = r.tries + 5'h1;
          if (verify_bit && r.at_max)
          begin
            next_r.fail    = 1'b1;
            next_r.sel_n   = 1'b1;
            next_r.pg_done = 1'b1;
            next_r.st      = ST_IDLE;
          end
          else if (verify_bit)
          begin
            next_r.sel_n   = 1'b1;
            next_r.pg_ok   = 1'b1;
            next_r.pg_done = 1'b1;
            next_r.st      = ST_IDLE;
          end
          else if (r.tries + 5'h1 >= `PROM_MAX_TRIES)
          begin
            next_r.fail    = 1'b1;
            next_r.sel_n   = 1'b1;
            next_r.pg_done = 1'b1;
            next_r.st      = ST_IDLE;
          end
          else
            next_r.st = ST_REST;
        end
      end
      default:
        next_r = r;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r       <= '0;
      r.sel_n <= 1'b1;
      r.st    <= ST_IDLE;
      busy    <= 1'b0;
    end
    else
    begin
      r    <= next_r;
      busy <= (next_r.st != ST_IDLE);
    end
  end

  // The device's own outputs are inputs here; both output styles read the same once selected.
  assign o_addr      = r.addr;
  assign o_sel_n     = r.sel_n;
  assign o_sel_hv    = r.sel_hv;
  assign o_vcc_hi    = r.vcc_hi;
  assign o_ramp_en   = r.ramp_en;
  assign o_ramp_hold = r.ramp_hold;
  assign o_ramp_oe   = r.ramp_oe;
  assign o_rdata     = r.rdata;
  assign o_rd_valid  = r.rd_valid;
  assign o_busy      = busy;
  assign o_pg_done   = r.pg_done;
  assign o_pg_ok     = r.pg_ok;
  assign o_fail      = r.fail;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_one_output_only: assert property ($onehot0(o_ramp_oe) && (o_ramp_en || o_ramp_oe == 8'h00))
    else $error("Programming current reaches more than one output.");
  a_select_before_hv: assert property (o_sel_hv |-> !o_sel_n && o_vcc_hi)
    else $error("Programming voltage applied without address and select.");
  a_vcc_before_hv: assert property ($rose(o_sel_hv) |-> $past(o_vcc_hi, 2) && !o_rdata[r.bsel])
    else $error("Programming voltage applied without a high supply zero check.");
  a_ramp_needs_hv: assert property (o_ramp_en |-> o_sel_hv)
    else $error("Current ramp active without select programming voltage.");
  a_hold_after_drop: assert property ($rose(o_ramp_hold) |-> $past(i_sense_drop) && o_ramp_en)
    else $error("Current hold started without a sensed drop.");
  a_hv_off_first: assert property ($fell(o_vcc_hi) && $past(r.st) == ST_VERIFY |-> !$past(o_sel_hv))
    else $error("Supply lowered while select programming voltage still high.");
  a_hv_off_after_cur: assert property ($fell(o_sel_hv) |-> !o_ramp_en && !$past(o_ramp_en))
    else $error("Select voltage dropped while current still flows.");
  a_tries_bounded: assert property (r.tries <= `PROM_MAX_TRIES)
    else $error("More than sixteen programming attempts.");
  a_fail_locks: assert property (o_fail |=> o_fail && (r.st != ST_REST))
    else $error("Programming resumed after device failure.");
  a_read_access: assert property (o_rd_valid |-> $past(!o_sel_n, 1) && $past(!o_sel_n, 2))
    else $error("Read data sampled before access delay elapsed.");
  a_ok_needs_one: assert property ($rose(o_pg_ok) |-> o_rdata[r.bsel] && !o_fail)
    else $error("Success reported without a verified one.");

  c_read_done: cover property (o_rd_valid);
  c_program_ok: cover property (o_pg_done && o_pg_ok && r.tries != 5'h0);
  c_program_retry: cover property ($rose(o_vcc_hi) && r.tries != 5'h0);
  c_device_fail: cover property ($rose(o_fail));

endmodule : prom_host

//--- rtl/prom_map.svh
// Timing constants shared by the fuse memory host controller.
`ifndef PROM_MAP_SVH
`define PROM_MAP_SVH

`define PROM_CLK_NS          100
`define PROM_WORDS           8192
`define PROM_T_ADDR_NS       55
`define PROM_T_SEL_NS        30
`define PROM_T_VCC_SETTLE_NS 10000
`define PROM_T_HV_SETTLE_NS  10000
`define PROM_T_HOLD_NS       100000
`define PROM_T_CUR_OFF_NS    1000
`define PROM_MAX_TRIES       5'h10

`define PROM_CYC(t) (((t) + `PROM_CLK_NS - 1) / `PROM_CLK_NS)
`define PROM_RD_CYC ((`PROM_CYC(`PROM_T_ADDR_NS) > `PROM_CYC(`PROM_T_SEL_NS)) ? \
                     `PROM_CYC(`PROM_T_ADDR_NS) : `PROM_CYC(`PROM_T_SEL_NS))
`define PROM_VCC_CYC `PROM_CYC(`PROM_T_VCC_SETTLE_NS)
`define PROM_HV_CYC  `PROM_CYC(`PROM_T_HV_SETTLE_NS)
`define PROM_HOLD_CYC `PROM_CYC(`PROM_T_HOLD_NS)
`define PROM_OFF_CYC `PROM_CYC(`PROM_T_CUR_OFF_NS)

`endif

//--- rtl/prom_pkg.sv
// Types and helper functions of the fuse memory host controller.
package prom_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RD_WAIT = 4'h1,
    ST_REST    = 4'h2,
    ST_SETTLE  = 4'h3,
    ST_HV      = 4'h4,
    ST_RAMP    = 4'h5,
    ST_HOLD    = 4'h6,
    ST_CUR_OFF = 4'h7,
    ST_VERIFY  = 4'h8
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [15:0] tmr;
    logic [4:0]  tries;
    logic        at_max;
    logic [12:0] addr;
    logic [2:0]  bsel;
    logic        sel_n;
    logic        sel_hv;
    logic        vcc_hi;
    logic        ramp_en;
    logic        ramp_hold;
    logic [7:0]  ramp_oe;
    logic [7:0]  rdata;
    logic        rd_valid;
    logic        pg_done;
    logic        pg_ok;
    logic        fail;
  } host_regs_t;

  typedef struct packed {
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic        prev;
    logic        rest_ok;
  } guard_regs_t;

  function automatic logic bit_of(input logic [7:0] d, input logic [2:0] b);
    return d[b];
  endfunction : bit_of

  function automatic logic [7:0] lane_of(input logic [2:0] b);
    return 8'h01 << b;
  endfunction : lane_of

endpackage : prom_pkg

//--- rtl/supply_duty_guard.sv
// Keeps the elevated supply off at least as long as it was last on.
`timescale 1ns/10ps
`include "prom_map.svh"
module supply_duty_guard
  import prom_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  duty_if.guard     du
);

  guard_regs_t r;
  guard_regs_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.prev = du.vcc_on;
    if (du.vcc_on)
    begin
      next_r.off_cnt = 16'h0;
      next_r.rest_ok = 1'b0;
      if (!r.prev)
        next_r.on_cnt = 16'h1;
      else if (r.on_cnt != 16'hffff)
        next_r.on_cnt = r.on_cnt + 16'h1;
    end
    else
    begin
      // Both counters saturate at the same value, so a very long burn still ends in a rest.
      if (r.off_cnt != 16'hffff)
        next_r.off_cnt = r.off_cnt + 16'h1;
      next_r.rest_ok = (next_r.off_cnt >= r.on_cnt);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    // Reset forgets the last burn, so whoever resets in mid-run must let the supply rest first.
    if (!i_nrst)
      r <= '{on_cnt: 16'h0, off_cnt: 16'h0, prev: 1'b0, rest_ok: 1'b1};
    else
      r <= next_r;
  end

  assign du.rest_ok = r.rest_ok;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_duty_rest_first: assert property ($rose(du.vcc_on) |-> $past(du.rest_ok))
    else $error("Supply raised before the rest time elapsed.");
  a_duty_off_blocks: assert property (du.rest_ok |-> (r.off_cnt >= r.on_cnt) && !r.prev)
    else $error("Rest reported while off time is shorter than on time.");

endmodule : supply_duty_guard

//--- sim/fuse_prom_read_and_program_tb.sv
// Self-checking bench for the fuse memory host controller.
`timescale 1ns/10ps
module fuse_prom_read_and_program_tb;
  typedef struct packed { logic pg; logic [7:0] val; } note_t;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_rd_req = 1'b0;
  logic        i_pg_req = 1'b0;
  logic [12:0] i_addr = 13'h0000;
  logic [2:0]  i_bit = 3'h0;
  logic [7:0]  i_data, o_ramp_oe, o_rdata;
  logic        i_sense_drop, i_ramp_at_max, abuse, o_sel_n, o_sel_hv, o_vcc_hi, o_ramp_en;
  logic        o_ramp_hold, o_rd_valid, o_busy, o_pg_done, o_pg_ok, o_fail;
  logic [12:0] o_addr;
  logic [7:0]  img [8192];
  note_t       notes [$];
  int          n_mismatch = 0;
  int          samples_checked = 0;

  prom_host dut (.i_clk, .i_nrst, .i_rd_req, .i_pg_req, .i_addr, .i_bit, .i_data, .i_sense_drop,
                 .i_ramp_at_max, .o_addr, .o_sel_n, .o_sel_hv, .o_vcc_hi, .o_ramp_en, .o_ramp_hold,
                 .o_ramp_oe, .o_rdata, .o_rd_valid, .o_busy, .o_pg_done, .o_pg_ok, .o_fail);
  prom_model mdl (.i_clk, .i_addr(o_addr), .i_sel_n(o_sel_n), .i_sel_hv(o_sel_hv), .i_vcc_hi(o_vcc_hi),
                  .i_ramp_en(o_ramp_en), .i_ramp_hold(o_ramp_hold), .i_ramp_oe(o_ramp_oe), .o_data(i_data),
                  .o_sense_drop(i_sense_drop), .o_ramp_at_max(i_ramp_at_max), .o_abuse(abuse));

  always #50 i_clk = ~i_clk;

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  always @(negedge i_clk)
    if (o_rd_valid === 1'b1 || o_pg_done === 1'b1)
    begin
      if (notes.size() == 0)
        chk(13'h1fff, 13'h0000);
      else
        chk({4'h0, o_pg_done, o_pg_done ? {6'h00, o_fail, o_pg_ok} : o_rdata}, {4'h0, notes.pop_front()});
    end

  // A poke raises a program request while the read is busy; it must be ignored.
  task automatic rd(input logic [12:0] a, input logic poke);
    int n;
    n = 2;
    @(negedge i_clk);
    i_addr = a;
    i_rd_req = 1'b1;
    notes.push_back({1'b0, img[a]});
    @(negedge i_clk);
    i_rd_req = 1'b0;
    i_pg_req = poke;
    chk({o_sel_n, o_addr}, {1'b0, a});
    @(negedge i_clk);
    i_pg_req = 1'b0;
    while (o_rd_valid !== 1'b1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(13'(n), 13'h0003);
  endtask : rd

  task automatic pg(input logic [12:0] a, input logic [2:0] b, input int bt, input int at, input int mx,
                    input logic [1:0] res);
    int n;
    n = 0;
    mdl.blow_try = bt;
    mdl.blow_at = at;
    mdl.max_at = mx;
    mdl.tries = 0;
    @(negedge i_clk);
    i_addr = a;
    i_bit = b;
    i_pg_req = 1'b1;
    notes.push_back({1'b1, 6'h00, res});
    @(negedge i_clk);
    i_pg_req = 1'b0;
    while (o_pg_done !== 1'b1 && n < 30000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk({12'h000, o_pg_done}, 13'h0001);
    if (res[0]) img[a][b] = 1'b1;
  endtask : pg

  initial
  begin
    #(100 * 90000);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    logic [12:0] a;
    logic [2:0]  b;
    void'($urandom(32'h64d99a8c));
    foreach (img[k]) img[k] = 8'h00;
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    chk({11'h000, o_busy, o_sel_n}, 13'h0001);
    rd(13'h0abc, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      // Random words stay in the upper half, clear of the words that the burn tests use.
      a = (k == 0) ? 13'h0000 : (k == 1) ? 13'h1fff : {1'b1, 12'($urandom)};
      img[a] = 8'($urandom);
      mdl.mem[a] = img[a];
      rd(a, k[0]);
    end
    b = 3'($urandom);
    pg(13'h0abc, b, 1, 20, 200, 2'b01);
    pg(13'h0abc, b, 1, 20, 200, 2'b01);
    chk(13'(mdl.tries), 13'h0000);
    pg(13'h0abc, b + 3'h1, 3, 20, 200, 2'b01);
    chk(13'(mdl.tries), 13'h0003);
    rd(13'h0abc, 1'b0);
    pg(13'h0123, b, 1, 50, 50, 2'b10);
    img[13'h0123][b] = 1'b1;
    pg(13'h0123, b + 3'h2, 1, 20, 200, 2'b10);
    chk(13'(mdl.tries), 13'h0000);
    rd(13'h0123, 1'b0);
    // The guard forgets the last burn across a reset, so the supply rests a full burn first.
    repeat (1500) @(negedge i_clk);
    i_nrst = 1'b0;
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    pg(13'h0456, b, 99, 20, 40, 2'b10);
    chk(13'(mdl.tries), 13'h0010);
    rd(13'h0456, 1'b0);
    chk({12'h000, abuse}, 13'h0000);
    print_verdict();
  end
endmodule : fuse_prom_read_and_program_tb

//--- sim/prom_model.sv
// Behavioural fuse memory that answers the host controller's pins.
`timescale 1ns/10ps
`include "prom_map.svh"
module prom_model
(
  input  wire logic        i_clk,
  input  wire logic [12:0] i_addr,
  input  wire logic        i_sel_n,
  input  wire logic        i_sel_hv,
  input  wire logic        i_vcc_hi,
  input  wire logic        i_ramp_en,
  input  wire logic        i_ramp_hold,
  input  wire logic [7:0]  i_ramp_oe,
  output logic      [7:0]  o_data,
  output logic             o_sense_drop,
  output logic             o_ramp_at_max,
  output logic             o_abuse
);
  logic [7:0] mem [8192];
  int         blow_try = 1;
  int         blow_at  = 20;
  int         max_at   = 200;
  int         tries    = 0;
  int         cnt      = 0;
  int         on_cnt   = 0;
  int         on_len   = 0;
  int         off_cnt  = 0;
  int         hold_cnt = 0;

  initial
  begin
    foreach (mem[k]) mem[k] = 8'h00;
    o_data = 8'h00;
    o_sense_drop = 1'b0;
    o_ramp_at_max = 1'b0;
    o_abuse = 1'b0;
  end

  // A released bus shows the inverse of its last value so a stale byte never matches by luck.
  always @(i_addr or i_sel_n or i_sel_hv or i_vcc_hi)
  begin
    o_data = ~o_data;
    if (!i_sel_n) o_data <= #55 mem[i_addr];
  end

  always @(posedge i_clk)
  begin
    if (i_ramp_en)
    begin
      if (!(i_vcc_hi && i_sel_hv && $onehot(i_ramp_oe))) o_abuse <= 1'b1;
      if (cnt == 0) tries <= tries + 1;
      if (!o_sense_drop) cnt <= cnt + 1;
      if (cnt == blow_at && tries >= blow_try)
      begin
        o_sense_drop <= 1'b1;
        mem[i_addr] <= mem[i_addr] | i_ramp_oe;
      end
      if (cnt == max_at) o_ramp_at_max <= 1'b1;
      if (i_ramp_hold)
      begin
        if (!o_sense_drop) o_abuse <= 1'b1;
        hold_cnt <= hold_cnt + 1;
      end
    end
    else
    begin
      // A sensed drop must be followed by a full constant-current hold before the ramp stops.
      if (o_sense_drop && hold_cnt < `PROM_HOLD_CYC) o_abuse <= 1'b1;
      hold_cnt <= 0;
      cnt <= 0;
      o_sense_drop <= 1'b0;
      o_ramp_at_max <= 1'b0;
    end
    // One cycle of slack allows for where the guard samples the edges.
    if (i_vcc_hi)
    begin
      if (on_cnt == 0 && off_cnt + 1 < on_len) o_abuse <= 1'b1;
      on_cnt <= on_cnt + 1;
    end
    else
    begin
      if (on_cnt != 0) on_len <= on_cnt;
      off_cnt <= (on_cnt != 0) ? 1 : off_cnt + 1;
      on_cnt <= 0;
    end
  end
endmodule : prom_model
